// ### design/eee_lpi_pkg.sv
// constants and types for the eee low-power-idle mmd register set
package eee_lpi_pkg;

   // ----------------------------------------
   // management frame layout
   // ----------------------------------------
   localparam logic [5:0]  PRE_LEN        = 6'h20;
   localparam logic [4:0]  HDR_LEN        = 5'h0C;
   localparam logic [4:0]  TA_LEN         = 5'h02;
   localparam logic [4:0]  DATA_LEN       = 5'h10;
   localparam logic [1:0]  OP_READ        = 2'h2;
   localparam logic [1:0]  OP_WRITE       = 2'h1;
   localparam logic [4:0]  PHY_ADDR       = 5'h01;

   // ----------------------------------------
   // portal registers
   // ----------------------------------------
   localparam logic [4:0]  STD_MMD_CTRL   = 5'h0D;
   localparam logic [4:0]  STD_MMD_DATA   = 5'h0E;
   localparam int          MODE_HI        = 15;
   localparam int          MODE_LO        = 14;
   localparam int          DEVAD_HI       = 4;
   localparam logic [1:0]  MODE_REG       = 2'h0;
   localparam logic [1:0]  MODE_DATA      = 2'h1;
   localparam logic [1:0]  MODE_INC_RW    = 2'h2;
   localparam logic [1:0]  MODE_INC_WR    = 2'h3;
   localparam logic [15:0] MMD_CTRL_RST   = 16'h0000;
   localparam logic [15:0] MMD_ADDR_RST   = 16'h0000;

   // ----------------------------------------
   // indirect register map
   // ----------------------------------------
   localparam logic [4:0]  DEV_PMA        = 5'h01;
   localparam logic [4:0]  DEV_PCS        = 5'h03;
   localparam logic [4:0]  DEV_AN         = 5'h07;
   localparam logic [15:0] REG_PMA_CTRL   = 16'h0000;
   localparam logic [15:0] REG_PMA_STAT   = 16'h0001;
   localparam logic [15:0] REG_PCS_CTRL   = 16'h0000;
   localparam logic [15:0] REG_EEE_ADV    = 16'h003C;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int          LPI_EN_BIT     = 12;
   localparam int          ENTERED_BIT    = 8;
   localparam int          NOW_BIT        = 3;
   localparam int          RX_STOP_BIT    = 10;
   localparam int          GIG_ADV_BIT    = 2;
   localparam int          FAST_ADV_BIT   = 1;
   localparam logic [15:0] PMA_CTRL_RST   = 16'h0000;
   localparam logic [15:0] PCS_CTRL_RST   = 16'h0C10;
   localparam logic [15:0] PCS_CTRL_RW    = 16'h0FF3;
   localparam logic        FAST_ADV_RST   = 1'h0;
   localparam logic        GIG_ADV_VAL    = 1'h0;

   typedef enum {S_IDLE, S_START, S_HDR, S_TA, S_DATA} frame_state_t;

endpackage: eee_lpi_pkg

// ### design/mmd_req_if.sv
// request carrier between the frame engine and the register bank
`timescale 1ns/100ps
interface mmd_req_if;
   logic        req;
   logic        wr;
   logic [4:0]  regad;
   logic [15:0] wdata;
   logic [15:0] rdata;

   modport serial (output req, wr, regad, wdata, input rdata);
   modport regs   (input req, wr, regad, wdata, output rdata);
endinterface: mmd_req_if

// ### design/mdio_frame_engine.sv
// management serial frame engine: samples the link clock and data pin
`timescale 1ns/100ps
module mdio_frame_engine
   import eee_lpi_pkg::*;
(
   input  wire logic  ref_clk,
   input  wire logic  rstn,
   input  wire logic  mdc,
   input  wire logic  mdio_in,
   output logic       mdio_out,
   output logic       mdio_oe,
   mmd_req_if.serial  req_port
);

   logic         mdc_s1, mdc_s2, mdc_s3;
   logic         mdio_s1, mdio_s2;
   logic         rise;
   logic         bit_in;
   frame_state_t state_q;
   logic [5:0]   ones_q;
   logic [4:0]   cnt_q;
   logic [10:0]  hdr_q;
   logic         is_rd_q;
   logic         req_q;
   logic         wr_q;
   logic [4:0]   regad_q;
   logic [15:0]  wdata_q;
   logic [15:0]  rd_sh_q;

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mdc_s1  <= 1'b0;
         mdc_s2  <= 1'b0;
         mdc_s3  <= 1'b0;
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
      end else begin
         mdc_s1  <= mdc;
         mdc_s2  <= mdc_s1;
         mdc_s3  <= mdc_s2;
         mdio_s1 <= mdio_in;
         mdio_s2 <= mdio_s1;
      end
   end

   assign rise   = mdc_s2 & ~mdc_s3;
   assign bit_in = mdio_s2;

   // ----------------------------------------
   // frame decode
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= S_IDLE;
         ones_q  <= '0;
         cnt_q   <= '0;
         hdr_q   <= '0;
         is_rd_q <= 1'b0;
         req_q   <= 1'b0;
         wr_q    <= 1'b0;
         regad_q <= '0;
         wdata_q <= '0;
      end else begin
         req_q <= 1'b0;
         if (rise) begin
            unique case (state_q)
               S_IDLE: begin
                  if (bit_in) begin
                     if (ones_q != PRE_LEN) ones_q <= ones_q + 6'h01;
                  end else begin
                     if (ones_q == PRE_LEN) state_q <= S_START;
                     ones_q <= '0;
                  end
               end
               S_START: begin
                  state_q <= bit_in ? S_HDR : S_IDLE;
                  cnt_q   <= '0;
               end
               S_HDR: begin
                  hdr_q <= {hdr_q[9:0], bit_in};
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == HDR_LEN - 5'h01) begin
                     cnt_q <= '0;
                     if (hdr_q[8:4] == PHY_ADDR && (hdr_q[10:9] == OP_READ || hdr_q[10:9] == OP_WRITE)) begin
                        state_q <= S_TA;
                        is_rd_q <= (hdr_q[10:9] == OP_READ);
                        regad_q <= {hdr_q[3:0], bit_in};
                        req_q   <= (hdr_q[10:9] == OP_READ);
                        wr_q    <= 1'b0;
                     end else begin
                        state_q <= S_IDLE;
                     end
                  end
               end
               S_TA: begin
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == TA_LEN - 5'h01) begin
                     cnt_q   <= '0;
                     state_q <= S_DATA;
                  end
               end
               S_DATA: begin
                  cnt_q <= cnt_q + 5'h01;
                  if (!is_rd_q) wdata_q <= {wdata_q[14:0], bit_in};
                  if (cnt_q == DATA_LEN - 5'h01) begin
                     cnt_q   <= '0;
                     state_q <= S_IDLE;
                     req_q   <= !is_rd_q;
                     wr_q    <= !is_rd_q;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // read data driver
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_sh_q  <= '0;
         mdio_out <= 1'b0;
         mdio_oe  <= 1'b0;
      end else if (req_q && !wr_q) begin
         rd_sh_q <= req_port.rdata;
      end else if (rise && is_rd_q && state_q == S_TA) begin
         mdio_oe <= 1'b1;
         if (cnt_q == '0) begin
            mdio_out <= 1'b0;
         end else begin
            mdio_out <= rd_sh_q[15];
            rd_sh_q  <= {rd_sh_q[14:0], 1'b0};
         end
      end else if (rise && is_rd_q && state_q == S_DATA) begin
         if (cnt_q == DATA_LEN - 5'h01) begin
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b0;
         end else begin
            mdio_out <= rd_sh_q[15];
            rd_sh_q  <= {rd_sh_q[14:0], 1'b0};
         end
      end
   end

   assign req_port.req   = req_q;
   assign req_port.wr    = wr_q;
   assign req_port.regad = regad_q;
   assign req_port.wdata = wdata_q;

endmodule: mdio_frame_engine

// ### design/eee_lpi_mmd_registers.sv
// eee low-power-idle mmd registers behind the management portal
//
// Overview of operation
// - idle enable bit, read/write, pma control bit 12, resets to 0.
// - latched flag at pma status bit 8 sets on entering idle, resets 0.
// - pma status bit 3 shows live idle state, read only.
// - rx clock may stop in 100M rx idle only if pcs bit 10; resets 1.
// - gigabit eee advertise bit always reads 0.
// - 100M eee advertise bit read/write, resets 0; management sets it.
// - latch-high flags hold once set until software reads them while pma idle is no longer active.
`timescale 1ns/100ps
module eee_lpi_mmd_registers
   import eee_lpi_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic mdc,
   input  wire logic mdio_in,
   output logic      mdio_out,
   output logic      mdio_oe,
   input  wire logic pma_lpi_active,
   input  wire logic rx_lpi_active,
   input  wire logic speed_100,
   output logic      lpi_enable,
   output logic      fast_eee_advertise,
   output logic      rx_clock_stop_ok
);

   mmd_req_if req_bus ();

   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic [15:0] mmd_ctrl_q;
   logic [15:0] mmd_addr_q;
   logic [15:0] pma_ctrl_q;
   logic [15:0] pcs_ctrl_q;
   logic        fast_adv_q;
   logic        idle_entered_latched_q;
   logic        idle_entered_latched_d;
   logic        rx_clock_stop_ok_q;
   logic        idle_now_flag;
   logic        rx_clock_stop_allow;
   logic        gig_eee_advertise;

   // ----------------------------------------
   // decode nets
   // ----------------------------------------
   logic [1:0]  mode;
   logic [4:0]  devad;
   logic        ctrl_wr;
   logic        data_hit;
   logic        addr_wr;
   logic        mmd_acc;
   logic        mmd_wr;
   logic        mmd_rd;
   logic        post_inc;
   logic        sel_pma_ctrl;
   logic        sel_pma_stat;
   logic        sel_pcs_ctrl;
   logic        sel_eee_adv;
   logic        entered_clr;
   logic        pma_ctrl_we;
   logic        pcs_ctrl_we;
   logic        eee_adv_we;
   logic [15:0] mmd_rdata;

   // ----------------------------------------
   // serial frame engine
   // ----------------------------------------
   mdio_frame_engine u_frame (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .mdc      (mdc),
      .mdio_in  (mdio_in),
      .mdio_out (mdio_out),
      .mdio_oe  (mdio_oe),
      .req_port (req_bus.serial)
   );

   // ----------------------------------------
   // portal decode
   // ----------------------------------------
   assign mode     = mmd_ctrl_q[MODE_HI:MODE_LO];
   assign devad    = mmd_ctrl_q[DEVAD_HI:0];
   assign ctrl_wr  = req_bus.req && req_bus.wr && req_bus.regad == STD_MMD_CTRL;
   assign data_hit = req_bus.req && req_bus.regad == STD_MMD_DATA;
   assign addr_wr  = data_hit && req_bus.wr && mode == MODE_REG;
   assign mmd_acc  = data_hit && mode != MODE_REG;
   assign mmd_wr   = mmd_acc && req_bus.wr;
   assign mmd_rd   = mmd_acc && !req_bus.wr;
   assign post_inc = mmd_acc && (mode == MODE_INC_RW || (mode == MODE_INC_WR && req_bus.wr));

   assign sel_pma_ctrl = devad == DEV_PMA && mmd_addr_q == REG_PMA_CTRL;
   assign sel_pma_stat = devad == DEV_PMA && mmd_addr_q == REG_PMA_STAT;
   assign sel_pcs_ctrl = devad == DEV_PCS && mmd_addr_q == REG_PCS_CTRL;
   assign sel_eee_adv  = devad == DEV_AN && mmd_addr_q == REG_EEE_ADV;

   // ----------------------------------------
   // register write strobes
   // ----------------------------------------
   assign pma_ctrl_we = mmd_wr && sel_pma_ctrl;
   assign pcs_ctrl_we = mmd_wr && sel_pcs_ctrl;
   assign eee_adv_we  = mmd_wr && sel_eee_adv;

   // ----------------------------------------
   // portal registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mmd_ctrl_q <= MMD_CTRL_RST;
      end else if (ctrl_wr) begin
         mmd_ctrl_q <= req_bus.wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mmd_addr_q <= MMD_ADDR_RST;
      end else if (addr_wr) begin
         mmd_addr_q <= req_bus.wdata;
      end else if (post_inc) begin
         mmd_addr_q <= mmd_addr_q + 16'h0001;
      end
   end

   // ----------------------------------------
   // pma/pmd control
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pma_ctrl_q <= PMA_CTRL_RST;
      end else if (pma_ctrl_we) begin
         pma_ctrl_q <= req_bus.wdata;
      end
   end

   assign lpi_enable = pma_ctrl_q[LPI_EN_BIT];

   // ----------------------------------------
   // pma/pmd status
   // ----------------------------------------
   assign idle_now_flag = pma_lpi_active;
   assign entered_clr   = mmd_rd && sel_pma_stat && !pma_lpi_active;
   assign idle_entered_latched_d = pma_lpi_active || (idle_entered_latched_q && !entered_clr);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         idle_entered_latched_q <= 1'b0;
      end else begin
         idle_entered_latched_q <= idle_entered_latched_d;
      end
   end

   // ----------------------------------------
   // pcs control
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pcs_ctrl_q <= PCS_CTRL_RST;
      end else if (pcs_ctrl_we) begin
         pcs_ctrl_q <= req_bus.wdata & PCS_CTRL_RW;
      end
   end

   assign rx_clock_stop_allow = pcs_ctrl_q[RX_STOP_BIT];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rx_clock_stop_ok_q <= 1'b0;
      end else begin
         rx_clock_stop_ok_q <= rx_clock_stop_allow && rx_lpi_active && speed_100;
      end
   end

   assign rx_clock_stop_ok = rx_clock_stop_ok_q;

   // ----------------------------------------
   // eee_local_advertisement
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fast_adv_q <= FAST_ADV_RST;
      end else if (eee_adv_we) begin
         fast_adv_q <= req_bus.wdata[FAST_ADV_BIT];
      end
   end

   assign fast_eee_advertise = fast_adv_q;
   assign gig_eee_advertise  = GIG_ADV_VAL;

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_comb begin
      mmd_rdata = '0;
      if (sel_pma_ctrl) begin
         mmd_rdata = pma_ctrl_q;
      end else if (sel_pma_stat) begin
         mmd_rdata[ENTERED_BIT] = idle_entered_latched_q;
         mmd_rdata[NOW_BIT]     = idle_now_flag;
      end else if (sel_pcs_ctrl) begin
         mmd_rdata = pcs_ctrl_q;
      end else if (sel_eee_adv) begin
         mmd_rdata[GIG_ADV_BIT]  = gig_eee_advertise;
         mmd_rdata[FAST_ADV_BIT] = fast_adv_q;
      end
   end

   // ----------------------------------------
   // portal read data
   // ----------------------------------------
   always_comb begin
      req_bus.rdata = '0;
      if (req_bus.regad == STD_MMD_CTRL) begin
         req_bus.rdata = mmd_ctrl_q;
      end else if (req_bus.regad == STD_MMD_DATA) begin
         req_bus.rdata = (mode == MODE_REG) ? mmd_addr_q : mmd_rdata;
      end
   end

endmodule: eee_lpi_mmd_registers

// ### sim/eee_lpi_mmd_registers_chk.sv
// port checker for the eee lpi register block
`timescale 1ns/100ps
module eee_lpi_mmd_registers_chk
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic mdc,
   input wire logic mdio_in,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   input wire logic pma_lpi_active,
   input wire logic rx_lpi_active,
   input wire logic speed_100,
   input wire logic lpi_enable,
   input wire logic fast_eee_advertise,
   input wire logic rx_clock_stop_ok
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence mdc_recent;
      $past(mdc, 3) || $past(mdc, 4) || $past(mdc, 5);
   endsequence
   sequence stop_cause;
      $past(rx_lpi_active) && $past(speed_100);
   endsequence

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   chk_stop_ok_cause: assert property (rx_clock_stop_ok |-> stop_cause)
      else $error("clock stop allowed outside 100M receive idle");
   chk_stop_ok_drop: assert property (!(rx_lpi_active && speed_100) |=> !rx_clock_stop_ok)
      else $error("clock stop allowance not withdrawn");
   chk_reset_values: assert property ($rose(rstn) |-> !lpi_enable && !fast_eee_advertise)
      else $error("config outputs not cleared by reset");
   chk_enable_steady: assert property ($changed(lpi_enable) |-> !mdio_oe && !$past(mdio_oe))
      else $error("idle enable changed during a read");
   chk_advert_steady: assert property ($changed(fast_eee_advertise) |-> !mdio_oe && !$past(mdio_oe))
      else $error("advertise bit changed during a read");
   chk_turn_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
      else $error("turnaround bit not driven low");
   chk_oe_rise_mdc: assert property ($rose(mdio_oe) |-> mdc_recent)
      else $error("pin drive started away from a clock rise");
   chk_oe_fall_mdc: assert property ($fell(mdio_oe) |-> mdc_recent)
      else $error("pin drive ended away from a clock rise");
   chk_oe_hold_bit: assert property ($rose(mdio_oe) |-> mdio_oe[*3])
      else $error("pin drive too short");
endmodule: eee_lpi_mmd_registers_chk

// ### sim/mdio_host_model.sv
// management host model: frames on the clock and data pins
`timescale 1ns/100ps
module mdio_host_model
   import eee_lpi_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic mdio_wire,
   output logic      mdc,
   output logic      host_en,
   output logic      host_bit
);
   initial begin
      mdc = 1'b0;
      host_en = 1'b0;
      host_bit = 1'b1;
   end

   // one frame, msb first; rd holds turnaround bit 2 and data
   task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                        output logic [16:0] rd);
      logic [63:0] f;
      f = {32'hFFFF_FFFF, 2'h1, op, PHY_ADDR, ra, (op == OP_READ) ? 2'h3 : 2'h2, wd};
      rd = 17'h00000;
      for (int i = 63; i >= 0; i--) begin
         @(posedge ref_clk);
         mdc <= 1'b0;
         host_en <= !(op == OP_READ && i < 18);
         host_bit <= f[i];
         repeat (8) @(posedge ref_clk);
         mdc <= 1'b1;
         if (i < 17) begin
            rd[i] = mdio_wire;
         end
         repeat (7) @(posedge ref_clk);
      end
      @(posedge ref_clk);
      mdc <= 1'b0;
      host_en <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask: frame
endmodule: mdio_host_model

// ### sim/eee_lpi_mmd_registers_tb.sv
// self-checking bench for the eee lpi register block
`timescale 1ns/100ps
module eee_lpi_mmd_registers_tb
   import eee_lpi_pkg::*;
;
   logic ref_clk, rstn, mdc, mdio_in, mdio_out, mdio_oe, host_en, host_bit;
   logic pma_lpi_active, rx_lpi_active, speed_100, lpi_enable, fast_eee_advertise, rx_clock_stop_ok;
   int   mismatches, samples_checked;
   logic [2:0] cfg_obs;
   localparam int OBS_EN   = 0;
   localparam int OBS_ADV  = 1;
   localparam int OBS_STOP = 2;

   // config outputs, read at the falling edge so they are settled
   assign cfg_obs = {rx_clock_stop_ok, fast_eee_advertise, lpi_enable};

   // released line is pulled up
   assign mdio_in = mdio_oe ? mdio_out : (host_en ? host_bit : 1'b1);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   eee_lpi_mmd_registers i_dut (.ref_clk(ref_clk), .rstn(rstn), .mdc(mdc), .mdio_in(mdio_in),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe), .pma_lpi_active(pma_lpi_active), .rx_lpi_active(rx_lpi_active),
      .speed_100(speed_100), .lpi_enable(lpi_enable), .fast_eee_advertise(fast_eee_advertise),
      .rx_clock_stop_ok(rx_clock_stop_ok));
   mdio_host_model i_host (.ref_clk(ref_clk), .mdio_wire(mdio_in), .mdc(mdc), .host_en(host_en),
      .host_bit(host_bit));

   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask: check

   task automatic bit_chk(input int sel, input logic exp);
      @(negedge ref_clk);
      check({15'h0000, cfg_obs[sel]}, {15'h0000, exp});
   endtask: bit_chk

   task automatic mmd(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] ra,
                      input logic [15:0] wd, output logic [16:0] r);
      i_host.frame(OP_WRITE, STD_MMD_CTRL, {MODE_REG, 9'h000, dev}, r);
      i_host.frame(OP_WRITE, STD_MMD_DATA, ra, r);
      i_host.frame(OP_WRITE, STD_MMD_CTRL, {MODE_DATA, 9'h000, dev}, r);
      i_host.frame(op, STD_MMD_DATA, wd, r);
   endtask: mmd

   task automatic wr(input logic [4:0] dev, input logic [15:0] ra, input logic [15:0] wd);
      logic [16:0] r;
      mmd(OP_WRITE, dev, ra, wd, r);
   endtask: wr

   task automatic rdc(input logic [4:0] dev, input logic [15:0] ra, input logic [15:0] exp);
      logic [16:0] r;
      mmd(OP_READ, dev, ra, 16'h0000, r);
      check(r[15:0], exp);
      check({15'h0000, r[16]}, 16'h0000);
   endtask: rdc

   // one bare portal frame; reads are compared
   task automatic portal(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                         input logic [15:0] exp);
      logic [16:0] r;
      i_host.frame(op, ra, wd, r);
      if (op == OP_READ) check(r[15:0], exp);
   endtask: portal

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask: print_verdict

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (90000) @(posedge ref_clk);
      mismatches++;
      print_verdict();
   end

   initial begin
      mismatches = 0;
      samples_checked = 0;
      rstn = 1'b0;
      pma_lpi_active = 1'b0;
      rx_lpi_active = 1'b0;
      speed_100 = 1'b0;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      bit_chk(OBS_EN, 1'b0);
      bit_chk(OBS_ADV, 1'b0);
      rdc(DEV_PMA, REG_PMA_CTRL, 16'h0000);
      rdc(DEV_PCS, REG_PCS_CTRL, 16'h0C10);
      rdc(DEV_AN, REG_EEE_ADV, 16'h0000);
      rdc(DEV_AN, 16'h003D, 16'h0000);
      $display("test reset values done");
      wr(DEV_PMA, REG_PMA_CTRL, 16'h1000);
      bit_chk(OBS_EN, 1'b1);
      rdc(DEV_PMA, REG_PMA_CTRL, 16'h1000);
      wr(DEV_AN, REG_EEE_ADV, 16'hFFFF);
      bit_chk(OBS_ADV, 1'b1);
      rdc(DEV_AN, REG_EEE_ADV, 16'h0002);
      $display("test config bits done");
      portal(OP_WRITE, STD_MMD_CTRL, {MODE_REG, 9'h000, DEV_PMA}, 16'h0000);
      portal(OP_WRITE, STD_MMD_DATA, REG_PMA_CTRL, 16'h0000);
      portal(OP_WRITE, STD_MMD_CTRL, {MODE_INC_RW, 9'h000, DEV_PMA}, 16'h0000);
      portal(OP_READ, STD_MMD_DATA, 16'h0000, 16'h1000);
      portal(OP_READ, STD_MMD_DATA, 16'h0000, 16'h0000);
      portal(OP_WRITE, STD_MMD_CTRL, {MODE_INC_WR, 9'h000, DEV_PMA}, 16'h0000);
      portal(OP_READ, STD_MMD_DATA, 16'h0000, 16'h0000);
      portal(OP_WRITE, STD_MMD_DATA, 16'hFFFF, 16'h0000);
      portal(OP_WRITE, STD_MMD_CTRL, {MODE_REG, 9'h000, DEV_PMA}, 16'h0000);
      portal(OP_READ, STD_MMD_CTRL, 16'h0000, 16'h0001);
      portal(OP_READ, STD_MMD_DATA, 16'h0000, 16'h0003);
      $display("test post increment done");
      @(posedge ref_clk);
      rx_lpi_active <= 1'b1;
      repeat (3) @(posedge ref_clk);
      bit_chk(OBS_STOP, 1'b0);
      @(posedge ref_clk);
      speed_100 <= 1'b1;
      repeat (3) @(posedge ref_clk);
      bit_chk(OBS_STOP, 1'b1);
      wr(DEV_PCS, REG_PCS_CTRL, 16'h0000);
      bit_chk(OBS_STOP, 1'b0);
      wr(DEV_PCS, REG_PCS_CTRL, 16'hFFFF);
      rdc(DEV_PCS, REG_PCS_CTRL, 16'h0FF3);
      bit_chk(OBS_STOP, 1'b1);
      $display("test clock stop done");
      @(posedge ref_clk);
      pma_lpi_active <= 1'b1;
      repeat (2) @(posedge ref_clk);
      pma_lpi_active <= 1'b0;
      rdc(DEV_PMA, REG_PMA_STAT, 16'h0100);
      rdc(DEV_PMA, REG_PMA_STAT, 16'h0000);
      @(posedge ref_clk);
      pma_lpi_active <= 1'b1;
      rdc(DEV_PMA, REG_PMA_STAT, 16'h0108);
      rdc(DEV_PMA, REG_PMA_STAT, 16'h0108);
      @(posedge ref_clk);
      pma_lpi_active <= 1'b0;
      rdc(DEV_PMA, REG_PMA_STAT, 16'h0100);
      $display("test idle flags done");
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      bit_chk(OBS_EN, 1'b0);
      rdc(DEV_AN, REG_EEE_ADV, 16'h0000);
      $display("test second reset done");
      print_verdict();
   end
endmodule: eee_lpi_mmd_registers_tb

bind eee_lpi_mmd_registers eee_lpi_mmd_registers_chk i_chk (.ref_clk(ref_clk), .rstn(rstn), .mdc(mdc),
   .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .pma_lpi_active(pma_lpi_active),
   .rx_lpi_active(rx_lpi_active), .speed_100(speed_100), .lpi_enable(lpi_enable),
   .fast_eee_advertise(fast_eee_advertise), .rx_clock_stop_ok(rx_clock_stop_ok));
